// file: verilog/eeprom_slave.sv
`timescale 1ns/1ps
`include "eeprom_consts.svh"

module eeprom_slave #(
	parameter logic [3:0] MEM_TYPE_ID   = 4'h5, // arbitrary value
	parameter logic [3:0] IDENT_TYPE_ID = 4'h6, // arbitrary value
	parameter int         PROG_CYCLES   = `EE_PROG_TIME_US * `EE_CLK_MHZ
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  reset_n,
	// two-wire bus
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_oe,
	// straps
	input  wire logic                  chip_sel_in_2,
	input  wire logic                  chip_sel_in_1,
	input  wire logic                  chip_sel_in_0,
	input  wire logic                  write_guard,
	// array port
	output logic                       mem_wr_en,
	output logic [`EE_ADDR_W-1:0]      mem_wr_addr,
	output eeprom_pkg::byte_t          mem_wr_data,
	output logic                       mem_wr_ident,
	output logic [`EE_ADDR_W-1:0]      mem_rd_addr,
	output logic                       mem_rd_ident,
	input  wire eeprom_pkg::byte_t     mem_rd_data,
	// status
	output logic                       busy,
	output logic                       ident_locked
);

	function automatic logic sel_hit(input eeprom_pkg::byte_t b, input logic [3:0] id,
		input logic [2:0] cs);
		sel_hit = (b[7:4] == id) && (b[3:1] == cs);
	endfunction : sel_hit

	function automatic logic [`EE_ADDR_W-1:0] in_page_inc(input logic [`EE_ADDR_W-1:0] a);
		in_page_inc = {a[`EE_ADDR_W-1:`EE_ROW_LSB], a[`EE_IDX_W-1:0] + 5'h01};
	endfunction : in_page_inc

	logic [5:0]              pins_s;
	logic                    scl_s;
	logic                    sda_s;
	logic [2:0]              cs_s;
	logic                    wg_s;

	// strap lines reset to zero, so every strap reads low until the synchroniser passes the pins two clocks after reset
	line_sync #(.W(6)) u_sync (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.async_in ({write_guard, chip_sel_in_2, chip_sel_in_1, chip_sel_in_0, sda_in, scl_in}),
		.sync_out (pins_s)
	);
	assign scl_s = pins_s[0];
	assign sda_s = pins_s[1];
	assign cs_s  = pins_s[4:2];
	assign wg_s  = pins_s[5];

	eeprom_pkg::link_state_t state_ff, nxt_state;
	logic [1:0]              prev_ff, nxt_prev;
	logic [3:0]              cnt_ff, nxt_cnt;
	eeprom_pkg::byte_t       shift_ff, nxt_shift;
	eeprom_pkg::byte_t       tx_ff, nxt_tx;
	logic                    ack_ff, nxt_ack;
	logic [`EE_ADDR_W-1:0]   addr_ff, nxt_addr;
	logic [`EE_ADDR_W-1:0]   last_ff, nxt_last;
	logic                    ident_ff, nxt_ident;
	logic                    a10_ff, nxt_a10;
	logic                    wrote_ff, nxt_wrote;
	logic                    stop_ok_ff, nxt_stop_ok;
	logic                    lock_ff, nxt_lock;
	logic                    lock_req_ff, nxt_lock_req;
	logic [5:0]              idx_ff, nxt_idx;
	logic [31:0]             wait_ff, nxt_wait;
	logic                    sda_oe_ff, nxt_sda_oe;
	logic                    mem_wr_en_ff, nxt_mem_wr_en;
	logic [`EE_ADDR_W-1:0]   mem_wr_addr_ff, nxt_mem_wr_addr;
	eeprom_pkg::byte_t       mem_wr_data_ff, nxt_mem_wr_data;
	logic                    mem_wr_ident_ff, nxt_mem_wr_ident;
	logic                    busy_ff, nxt_busy;
	logic [1:0]              settle_ff, nxt_settle;
	logic                    sda_out_ff;

	logic                    scl_rise, scl_fall, start_det, stop_det;
	eeprom_pkg::byte_t       rx;
	logic                    buf_clear, buf_we;
	eeprom_pkg::byte_t       buf_data;
	logic                    buf_valid;

	// edges held off until the synchroniser, cleared low, has caught the idle-high lines
	assign scl_rise  = scl_s & ~prev_ff[0] & settle_ff[1];
	assign scl_fall  = ~scl_s & prev_ff[0] & settle_ff[1];
	assign start_det = scl_s & prev_ff[0] & ~sda_s & prev_ff[1] & settle_ff[1];
	assign stop_det  = scl_s & prev_ff[0] & sda_s & ~prev_ff[1] & settle_ff[1];
	assign rx        = {shift_ff[6:0], sda_s};

	// bytes wait here until the programming cycle, so a cut write leaves the array alone
	page_latch u_latch (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.clear    (buf_clear),
		.wr_en    (buf_we),
		.wr_idx   (addr_ff[`EE_IDX_W-1:0]),
		.wr_data  (rx),
		.rd_idx   (idx_ff[`EE_IDX_W-1:0]),
		.rd_data  (buf_data),
		.rd_valid (buf_valid)
	);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_prev = settle_ff[1] ? {sda_s, scl_s} : 2'h3;
		nxt_settle = {settle_ff[0], 1'b1};
		nxt_cnt = cnt_ff;           nxt_shift = shift_ff;
		nxt_tx = tx_ff;             nxt_ack = ack_ff;
		nxt_addr = addr_ff;         nxt_last = last_ff;
		nxt_ident = ident_ff;       nxt_a10 = a10_ff;
		nxt_wrote = wrote_ff;       nxt_stop_ok = stop_ok_ff;
		nxt_lock = lock_ff;         nxt_lock_req = lock_req_ff;
		nxt_idx = idx_ff;           nxt_wait = wait_ff;
		nxt_sda_oe = sda_oe_ff;     nxt_mem_wr_en = 1'b0;
		nxt_mem_wr_addr = mem_wr_addr_ff;
		nxt_mem_wr_data = mem_wr_data_ff;
		nxt_mem_wr_ident = mem_wr_ident_ff;
		buf_clear = 1'b0;           buf_we = 1'b0;
		case (state_ff)
			eeprom_pkg::ST_FLUSH:
			begin
				nxt_sda_oe = 1'b0;
				if (idx_ff == 6'(`EE_PAGE_BYTES))
				begin
					nxt_state = eeprom_pkg::ST_WAIT;
					nxt_wait  = 32'h0;
				end
				else
				begin
					nxt_mem_wr_en    = buf_valid & ~(ident_ff & a10_ff);
					nxt_mem_wr_addr  = {addr_ff[`EE_ADDR_W-1:`EE_ROW_LSB],
						idx_ff[`EE_IDX_W-1:0]};
					nxt_mem_wr_data  = buf_data;
					nxt_mem_wr_ident = ident_ff;
					nxt_idx          = idx_ff + 6'h01;
				end
			end
			eeprom_pkg::ST_WAIT:
			begin
				nxt_sda_oe = 1'b0;
				nxt_wait   = wait_ff + 32'h1;
				if (wait_ff == 32'(PROG_CYCLES - 1))
				begin
					nxt_state    = eeprom_pkg::ST_IDLE;
					nxt_addr     = last_ff + 13'h0001;
					nxt_lock     = lock_ff | lock_req_ff;
					nxt_lock_req = 1'b0;
				end
			end
			default:
			begin
				if (scl_rise && cnt_ff != `EE_ACK_SLOT)
				begin
					nxt_shift   = rx;
					nxt_cnt     = cnt_ff + 4'h1;
					nxt_stop_ok = stop_ok_ff & (cnt_ff == 4'h0);
					if (cnt_ff == `EE_LAST_DATA_BIT)
					begin
						nxt_ack = 1'b0;
						case (state_ff)
							eeprom_pkg::ST_DEVSEL:
							begin
								if (sel_hit(rx, MEM_TYPE_ID, cs_s) ||
									sel_hit(rx, IDENT_TYPE_ID, cs_s))
								begin
									nxt_ack   = 1'b1;
									nxt_ident = (rx[7:4] == IDENT_TYPE_ID);
									if (!rx[0])
									begin
										nxt_wrote    = 1'b0;
										nxt_lock_req = 1'b0;
										buf_clear    = 1'b1;
									end
								end
								else
									nxt_state = eeprom_pkg::ST_IDLE;
							end
							eeprom_pkg::ST_ADDR_HI:
							begin
								nxt_addr[`EE_ADDR_W-1:8] = rx[`EE_ADDR_W-9:0];
								nxt_a10 = rx[`EE_LOCK_SEL_BIT-8];
								nxt_ack = 1'b1;
							end
							eeprom_pkg::ST_ADDR_LO:
							begin
								nxt_addr[7:0] = rx;
								nxt_ack = 1'b1;
							end
							eeprom_pkg::ST_WDATA:
							begin
								// guard and lock refuse data only, never select or address
								if (!wg_s && !(ident_ff && lock_ff))
								begin
									nxt_ack   = 1'b1;
									nxt_wrote = 1'b1;
									if (ident_ff && a10_ff)
										nxt_lock_req = lock_req_ff | rx[`EE_LOCK_DATA_BIT];
									else
									begin
										buf_we   = 1'b1;
										nxt_last = addr_ff;
										nxt_addr = in_page_inc(addr_ff);
									end
								end
							end
							default:
								nxt_ack = 1'b0;
						endcase
					end
				end
				else if (scl_rise)
				begin
					nxt_cnt = 4'h0;
					case (state_ff)
						eeprom_pkg::ST_DEVSEL:
						begin
							if (shift_ff[0])
							begin
								nxt_state = eeprom_pkg::ST_RDATA;
								nxt_tx    = (ident_ff && lock_ff) ? 8'hff : mem_rd_data;
								nxt_addr  = addr_ff + 13'h0001;
							end
							else
								nxt_state = eeprom_pkg::ST_ADDR_HI;
						end
						eeprom_pkg::ST_ADDR_HI:
							nxt_state = eeprom_pkg::ST_ADDR_LO;
						eeprom_pkg::ST_ADDR_LO:
							nxt_state = eeprom_pkg::ST_WDATA;
						eeprom_pkg::ST_WDATA:
							nxt_stop_ok = ack_ff;
						eeprom_pkg::ST_RDATA:
						begin
							if (sda_s)
								nxt_state = eeprom_pkg::ST_IDLE;
							else
							begin
								nxt_tx   = (ident_ff && lock_ff) ? 8'hff : mem_rd_data;
								nxt_addr = addr_ff + 13'h0001;
							end
						end
						default:
							nxt_cnt = 4'h0;
					endcase
				end
				if (scl_fall)
				begin
					if (cnt_ff == `EE_ACK_SLOT)
						nxt_sda_oe = ack_ff;
					else if (state_ff == eeprom_pkg::ST_RDATA)
					begin
						nxt_sda_oe = ~tx_ff[7];
						nxt_tx     = {tx_ff[6:0], 1'b1};
					end
					else
						nxt_sda_oe = 1'b0;
				end
				if (start_det)
				begin
					nxt_state   = eeprom_pkg::ST_DEVSEL;
					nxt_cnt     = 4'h0;
					nxt_sda_oe  = 1'b0;
					nxt_stop_ok = 1'b0;
				end
				else if (stop_det)
				begin
					nxt_sda_oe = 1'b0;
					if (state_ff == eeprom_pkg::ST_WDATA && stop_ok_ff && wrote_ff)
					begin
						nxt_state = eeprom_pkg::ST_FLUSH;
						nxt_idx   = 6'h00;
					end
					else
						nxt_state = eeprom_pkg::ST_IDLE;
				end
			end
		endcase
		nxt_busy = (nxt_state == eeprom_pkg::ST_FLUSH) || (nxt_state == eeprom_pkg::ST_WAIT);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			state_ff <= eeprom_pkg::ST_IDLE;  prev_ff <= 2'h3;
			cnt_ff <= 4'h0;       shift_ff <= 8'h00;   tx_ff <= 8'hff;
			ack_ff <= 1'b0;       addr_ff <= '0;       last_ff <= '0;
			ident_ff <= 1'b0;     a10_ff <= 1'b0;      wrote_ff <= 1'b0;
			stop_ok_ff <= 1'b0;   lock_ff <= 1'b0;     lock_req_ff <= 1'b0;
			idx_ff <= 6'h00;      wait_ff <= 32'h0;    sda_oe_ff <= 1'b0;
			mem_wr_en_ff <= 1'b0; mem_wr_addr_ff <= '0; mem_wr_data_ff <= 8'h00;
			mem_wr_ident_ff <= 1'b0; busy_ff <= 1'b0;  sda_out_ff <= 1'b0;
			settle_ff <= 2'h0;
			mem_rd_addr <= '0;    mem_rd_ident <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;   prev_ff <= nxt_prev;
			cnt_ff <= nxt_cnt;       shift_ff <= nxt_shift; tx_ff <= nxt_tx;
			ack_ff <= nxt_ack;       addr_ff <= nxt_addr;   last_ff <= nxt_last;
			ident_ff <= nxt_ident;   a10_ff <= nxt_a10;     wrote_ff <= nxt_wrote;
			stop_ok_ff <= nxt_stop_ok; lock_ff <= nxt_lock; lock_req_ff <= nxt_lock_req;
			idx_ff <= nxt_idx;       wait_ff <= nxt_wait;   sda_oe_ff <= nxt_sda_oe;
			mem_wr_en_ff <= nxt_mem_wr_en;     mem_wr_addr_ff <= nxt_mem_wr_addr;
			mem_wr_data_ff <= nxt_mem_wr_data; mem_wr_ident_ff <= nxt_mem_wr_ident;
			busy_ff <= nxt_busy;     sda_out_ff <= 1'b0;
			settle_ff <= nxt_settle;
			mem_rd_addr <= addr_ff;  mem_rd_ident <= ident_ff;
		end
	end

	assign sda_out      = sda_out_ff;
	assign sda_oe       = sda_oe_ff;
	assign mem_wr_en    = mem_wr_en_ff;
	assign mem_wr_addr  = mem_wr_addr_ff;
	assign mem_wr_data  = mem_wr_data_ff;
	assign mem_wr_ident = mem_wr_ident_ff;
	assign busy         = busy_ff;
	assign ident_locked = lock_ff;

	property p_prog_quiet;
		@(posedge clk_sys) disable iff (!reset_n)
		busy_ff |=> !sda_oe_ff;
	endproperty
	a_prog_quiet: assert property (p_prog_quiet) else $error("sda driven while busy");

	property p_start_sel;
		@(posedge clk_sys) disable iff (!reset_n)
		(start_det && !busy_ff) |=> (state_ff == eeprom_pkg::ST_DEVSEL) && !sda_oe_ff;
	endproperty
	a_start_sel: assert property (p_start_sel) else $error("start not taken");

	property p_read_stop;
		@(posedge clk_sys) disable iff (!reset_n)
		(stop_det && !busy_ff && state_ff != eeprom_pkg::ST_WDATA)
			|=> state_ff == eeprom_pkg::ST_IDLE;
	endproperty
	a_read_stop: assert property (p_read_stop) else $error("stop not to standby");

	property p_no_false_prog;
		@(posedge clk_sys) disable iff (!reset_n)
		(stop_det && !busy_ff && !(state_ff == eeprom_pkg::ST_WDATA && stop_ok_ff && wrote_ff))
			|=> !busy_ff [*2];
	endproperty
	a_no_false_prog: assert property (p_no_false_prog) else $error("false program");

	property p_guard_nack;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_ff == eeprom_pkg::ST_WDATA && scl_rise && cnt_ff == `EE_LAST_DATA_BIT && wg_s)
			|=> !ack_ff && !wrote_ff;
	endproperty
	a_guard_nack: assert property (p_guard_nack) else $error("guarded data acked");

	property p_mismatch;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_ff == eeprom_pkg::ST_DEVSEL && scl_rise && cnt_ff == `EE_LAST_DATA_BIT
			&& rx[3:1] != cs_s) |=> state_ff == eeprom_pkg::ST_IDLE && !ack_ff;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("foreign select answered");

	property p_addr_ack;
		@(posedge clk_sys) disable iff (!reset_n)
		((state_ff == eeprom_pkg::ST_ADDR_HI || state_ff == eeprom_pkg::ST_ADDR_LO)
			&& scl_rise && cnt_ff == `EE_LAST_DATA_BIT) |=> ack_ff;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address byte not acked");

	property p_row_fixed;
		@(posedge clk_sys) disable iff (!reset_n)
		mem_wr_en_ff |-> busy_ff && mem_wr_addr_ff[12:5] == addr_ff[12:5];
	endproperty
	a_row_fixed: assert property (p_row_fixed) else $error("write left its row");

	property p_lock_nack;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_ff == eeprom_pkg::ST_WDATA && ident_ff && lock_ff && scl_rise
			&& cnt_ff == `EE_LAST_DATA_BIT) |=> !ack_ff;
	endproperty
	a_lock_nack: assert property (p_lock_nack) else $error("locked page data acked");

	property p_read_nack;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_ff == eeprom_pkg::ST_RDATA && scl_rise && cnt_ff == `EE_ACK_SLOT && sda_s
			&& !start_det && !stop_det) |=> state_ff == eeprom_pkg::ST_IDLE ##1 !sda_oe_ff;
	endproperty
	a_read_nack: assert property (p_read_nack) else $error("nack did not end read");

endmodule : eeprom_slave

// file: verilog/eeprom_consts.svh
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH

// array and page geometry
`define EE_ADDR_W        13
`define EE_IDX_W         5
`define EE_PAGE_BYTES    32
`define EE_ROW_LSB       5

// identification page lock bits
`define EE_LOCK_SEL_BIT  10
`define EE_LOCK_DATA_BIT 1

// bit slot positions inside one byte frame
`define EE_LAST_DATA_BIT 4'h7
`define EE_ACK_SLOT      4'h8

// timing
`define EE_CLK_MHZ       10
`define EE_PROG_TIME_US  5000

`endif

// file: verilog/eeprom_pkg.sv
package eeprom_pkg;

	typedef enum logic [7:0] {
		ST_IDLE    = 8'h01,
		ST_DEVSEL  = 8'h02,
		ST_ADDR_HI = 8'h04,
		ST_ADDR_LO = 8'h08,
		ST_WDATA   = 8'h10,
		ST_RDATA   = 8'h20,
		ST_FLUSH   = 8'h40,
		ST_WAIT    = 8'h80
	} link_state_t;

	typedef logic [7:0] byte_t;

endpackage : eeprom_pkg

// file: verilog/line_sync.sv
`timescale 1ns/1ps

module line_sync #(
	parameter int W = 2
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         reset_n,
	// pins and their synchronised copies
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_sync;

	// first stage feeds only the second stage
	always_comb
	begin
		nxt_meta = async_in;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign sync_out = sync_ff;

endmodule : line_sync

// file: verilog/page_latch.sv
`timescale 1ns/1ps
`include "eeprom_consts.svh"

module page_latch (
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   reset_n,
	// fill side
	input  wire logic                   clear,
	input  wire logic                   wr_en,
	input  wire logic [`EE_IDX_W-1:0]   wr_idx,
	input  wire eeprom_pkg::byte_t      wr_data,
	// drain side
	input  wire logic [`EE_IDX_W-1:0]   rd_idx,
	output eeprom_pkg::byte_t           rd_data,
	output logic                        rd_valid
);

	eeprom_pkg::byte_t              byte_mem [0:`EE_PAGE_BYTES-1];
	logic [`EE_PAGE_BYTES-1:0]      valid_ff;
	logic [`EE_PAGE_BYTES-1:0]      nxt_valid;

	// a rewritten position simply takes the newest byte
	always_comb
	begin
		nxt_valid = valid_ff;
		if (clear)
			nxt_valid = '0;
		else if (wr_en)
			nxt_valid[wr_idx] = 1'b1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			valid_ff <= '0;
		else
			valid_ff <= nxt_valid;
	end

	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
			byte_mem[wr_idx] <= wr_data;
	end

	assign rd_data  = byte_mem[rd_idx];
	assign rd_valid = valid_ff[rd_idx];

endmodule : page_latch

// file: verif/bus_master_model.sv
`timescale 1ns/1ps

module bus_master_model (
	// clock
	input  wire logic clk_sys,
	// two-wire bus
	input  wire logic sda_line,
	output logic      scl_out,
	output logic      sda_pull
);
	// bus clock stands high between frames
	initial
	begin
		scl_out  = 1'b1;
		sda_pull = 1'b0;
	end

	// quarter of an 800 ns bus period
	task automatic quarter;
		repeat (2) @(negedge clk_sys);
	endtask : quarter

	task automatic start_cond;
		quarter();
		sda_pull = 1'b0;
		quarter();
		scl_out = 1'b1;
		quarter();
		sda_pull = 1'b1;
		quarter();
		scl_out = 1'b0;
	endtask : start_cond

	task automatic stop_cond;
		quarter();
		sda_pull = 1'b1;
		quarter();
		scl_out = 1'b1;
		quarter();
		sda_pull = 1'b0;
		quarter();
	endtask : stop_cond

	// data moves only while the clock is low
	task automatic bit_cycle(input logic b, output logic seen);
		quarter();
		sda_pull = ~b;
		quarter();
		scl_out = 1'b1;
		quarter();
		seen = sda_line;
		quarter();
		scl_out = 1'b0;
	endtask : bit_cycle

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_cycle(d[i], s);
		bit_cycle(1'b1, s);
		ack = ~s;
	endtask : send_byte

	task automatic recv_byte(input logic give_ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_cycle(1'b1, d[i]);
		bit_cycle(~give_ack, s);
	endtask : recv_byte
endmodule : bus_master_model

// file: verif/tb_eeprom_slave.sv
`timescale 1ns/1ps
`include "eeprom_consts.svh"

module tb_eeprom_slave;
	localparam logic [3:0] MEM_ID = 4'h5; // arbitrary value
	localparam logic [3:0] IDP_ID = 4'h6; // arbitrary value
	logic                          clk_sys;
	logic                          reset_n;
	logic                          scl;
	logic                          pull_m;
	logic                          sda_out;
	logic                          sda_oe;
	logic [2:0]                    chip_sel;
	logic                          write_guard;
	logic                          mem_wr_en;
	logic [`EE_ADDR_W-1:0]         mem_wr_addr;
	eeprom_pkg::byte_t             mem_wr_data;
	logic                          mem_wr_ident;
	logic [`EE_ADDR_W-1:0]         mem_rd_addr;
	logic                          mem_rd_ident;
	eeprom_pkg::byte_t             mem_rd_data;
	logic                          busy;
	logic                          ident_locked;
	eeprom_pkg::byte_t             mem [8192];
	eeprom_pkg::byte_t             ref_mem [8192];
	eeprom_pkg::byte_t             idp [32];
	eeprom_pkg::byte_t             ref_id [32];
	int                            errors;
	int                            compares;
	wire                           sda = ~(pull_m | (sda_oe & ~sda_out));

	// large enough that a poll fits inside the program cycle
	eeprom_slave #(.MEM_TYPE_ID(MEM_ID), .IDENT_TYPE_ID(IDP_ID), .PROG_CYCLES(200)) u_dut (
		.clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .chip_sel_in_2(chip_sel[2]),
		.chip_sel_in_1(chip_sel[1]), .chip_sel_in_0(chip_sel[0]),
		.write_guard(write_guard), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
		.mem_wr_data(mem_wr_data), .mem_wr_ident(mem_wr_ident),
		.mem_rd_addr(mem_rd_addr), .mem_rd_ident(mem_rd_ident),
		.mem_rd_data(mem_rd_data), .busy(busy), .ident_locked(ident_locked)
	);

	bus_master_model u_master (
		.clk_sys(clk_sys), .sda_line(sda), .scl_out(scl), .sda_pull(pull_m)
	);

	// array cells kept outside the block
	assign mem_rd_data = mem_rd_ident ? idp[mem_rd_addr[4:0]] : mem[mem_rd_addr];

	always @(posedge clk_sys)
	begin
		if (mem_wr_en === 1'b1)
		begin
			if (mem_wr_ident)
				idp[mem_wr_addr[4:0]] <= mem_wr_data;
			else
				mem[mem_wr_addr] <= mem_wr_data;
		end
	end

	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic test_done;
		if (errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	task automatic write_seq(input logic [3:0] ty, input logic [15:0] addr,
		input logic [7:0] d0, input int n, input logic exp_ack);
		logic a;
		u_master.start_cond();
		u_master.send_byte({ty, chip_sel, 1'b0}, a);
		check("select ack", a, 1'b1);
		u_master.send_byte(addr[15:8], a);
		check("addr hi ack", a, 1'b1);
		u_master.send_byte(addr[7:0], a);
		check("addr lo ack", a, 1'b1);
		for (int k = 0; k < n; k++)
		begin
			u_master.send_byte(d0 + 8'(k), a);
			check("data ack", a, exp_ack);
		end
	endtask : write_seq

	// stop, then busy must come (or not) and the bus must be deaf meanwhile
	task automatic stop_prog(input logic expect_busy);
		int t;
		logic a;
		u_master.stop_cond();
		t = 0;
		while (busy !== 1'b1 && t < 20)
		begin
			@(negedge clk_sys);
			t++;
		end
		check("busy start", busy, expect_busy);
		if (expect_busy)
		begin
			u_master.start_cond();
			u_master.send_byte({MEM_ID, chip_sel, 1'b0}, a);
			check("poll ack", a, 1'b0);
			u_master.stop_cond();
		end
		t = 0;
		while (busy !== 1'b0 && t < 600)
		begin
			@(negedge clk_sys);
			t++;
		end
		check("busy end", busy, 1'b0);
	endtask : stop_prog

	task automatic read_seq(input logic [3:0] ty, input logic [15:0] addr,
		input logic random, input int n);
		logic a;
		logic [7:0] d;
		logic [12:0] p;
		p = addr[12:0];
		if (random)
		begin
			u_master.start_cond();
			u_master.send_byte({ty, chip_sel, 1'b0}, a);
			u_master.send_byte(addr[15:8], a);
			u_master.send_byte(addr[7:0], a);
		end
		u_master.start_cond();
		u_master.send_byte({ty, chip_sel, 1'b1}, a);
		check("read select ack", a, 1'b1);
		for (int k = 0; k < n; k++)
		begin
			// last byte left unacknowledged ends the read
			u_master.recv_byte(k < n - 1, d);
			if (ty == MEM_ID)
				check("read data", d, ref_mem[p]);
			else
				check("ident data", d, ref_id[p[4:0]]);
			p++;
		end
		u_master.stop_cond();
	endtask : read_seq

	task automatic byte_write_test;
		write_seq(MEM_ID, 16'he123, 8'h3c, 1, 1'b1);
		ref_mem[13'h0123] = 8'h3c;
		stop_prog(1'b1);
		read_seq(MEM_ID, 16'h0124, 1'b0, 1);
		read_seq(MEM_ID, 16'h0123, 1'b1, 1);
	endtask : byte_write_test

	task automatic page_write_test;
		write_seq(MEM_ID, 16'h03de, 8'ha0, 3, 1'b1);
		ref_mem[13'h03de] = 8'ha0;
		ref_mem[13'h03df] = 8'ha1;
		ref_mem[13'h03c0] = 8'ha2;
		stop_prog(1'b1);
		read_seq(MEM_ID, 16'h03c1, 1'b0, 1);
		read_seq(MEM_ID, 16'h03de, 1'b1, 2);
		write_seq(MEM_ID, 16'h0100, 8'h40, 32, 1'b1);
		for (int k = 0; k < 32; k++)
			ref_mem[13'h0100 + 13'(k)] = 8'h40 + 8'(k);
		stop_prog(1'b1);
		read_seq(MEM_ID, 16'h00ff, 1'b1, 34);
		read_seq(MEM_ID, 16'h1ffe, 1'b1, 3);
	endtask : page_write_test

	task automatic refusal_test;
		logic a;
		write_guard = 1'b1;
		write_seq(MEM_ID, 16'h0200, 8'h11, 2, 1'b0);
		stop_prog(1'b0);
		read_seq(MEM_ID, 16'h0200, 1'b1, 2);
		write_guard = 1'b0;
		write_seq(MEM_ID, 16'h0300, 8'h00, 0, 1'b1);
		stop_prog(1'b0);
		u_master.start_cond();
		u_master.send_byte({MEM_ID, chip_sel ^ 3'h1, 1'b0}, a);
		check("foreign select", a, 1'b0);
		u_master.send_byte(8'h00, a);
		check("standby byte", a, 1'b0);
		u_master.stop_cond();
		read_seq(MEM_ID, 16'h0300, 1'b1, 1);
	endtask : refusal_test

	task automatic ident_test;
		write_seq(IDP_ID, 16'hf807, 8'h70, 2, 1'b1);
		ref_id[7] = 8'h70;
		ref_id[8] = 8'h71;
		stop_prog(1'b1);
		read_seq(IDP_ID, 16'h0007, 1'b1, 2);
		write_seq(IDP_ID, 16'h0400, 8'hfd, 1, 1'b1);
		stop_prog(1'b1);
		check("no lock", ident_locked, 1'b0);
		write_seq(IDP_ID, 16'h0400, 8'h02, 1, 1'b1);
		stop_prog(1'b1);
		check("locked", ident_locked, 1'b1);
		write_seq(IDP_ID, 16'h0001, 8'h55, 1, 1'b0);
		stop_prog(1'b0);
		write_seq(IDP_ID, 16'h0400, 8'h02, 1, 1'b0);
		stop_prog(1'b0);
		for (int k = 0; k < 32; k++)
			ref_id[k] = 8'hff;
		read_seq(IDP_ID, 16'h0007, 1'b1, 2);
	endtask : ident_test

	// watchdog well beyond the expected run
	initial
	begin
		#(6000000);
		errors++;
		test_done();
	end

	initial
	begin
		errors = 0;
		compares = 0;
		reset_n = 1'b0;
		chip_sel = 3'h5;
		write_guard = 1'b0;
		for (int i = 0; i < 8192; i++)
		begin
			mem[i] = 8'(i) ^ 8'h5a;
			ref_mem[i] = 8'(i) ^ 8'h5a;
		end
		for (int i = 0; i < 32; i++)
		begin
			idp[i] = 8'hff;
			ref_id[i] = 8'hff;
		end
		repeat (20) @(negedge clk_sys);
		reset_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		byte_write_test();
		page_write_test();
		refusal_test();
		ident_test();
		test_done();
	end
endmodule : tb_eeprom_slave
